// ---- bench/crtsc_raster_gen.sv ----
// Raster counter model that feeds the block its retrace, display end and character timing
`timescale 1ns/1ns
module crtsc_raster_gen
  import crtsc_pkg::*;
#(
  parameter int COLS = 8,
  parameter int VIS = 6,
  parameter int RETR = 8,
  parameter int TOTAL = 10
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic run,
  output crtsc_raster_t raster
);
  logic [7:0] col;
  logic [7:0] line;
  // Stopping freezes the position but drops every level, so a restart gives fresh edges
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      col <= 8'h00;
      line <= 8'h00;
      raster <= '0;
    end else if (!run) begin
      raster <= '0;
    end else begin
      col <= (col == 8'(COLS - 1)) ? 8'h00 : col + 8'h01;
      if (col == 8'(COLS - 1)) begin
        line <= (line == 8'(TOTAL - 1)) ? 8'h00 : line + 8'h01;
      end
      raster.char_tick <= col != 8'(COLS - 1);
      raster.row_end <= col == 8'(COLS - 1);
      raster.vertical_display_end <= line >= 8'(VIS);
      raster.vertical_retrace <= line >= 8'(RETR);
    end
  end
endmodule

// ---- bench/test_crt_scroll_cursor_vint.sv ----
// Self-checking bench for the scroll, cursor and vertical interrupt block
`timescale 1ns/1ns
module test_crt_scroll_cursor_vint;
  import crtsc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic run = 1'b0, irq_ack = 1'b0, mon_en = 1'b0, exp_q = 1'b0, exp_ok = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic cursor_out, vertical_irq_out_o, vertical_irq_out_oe, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd;
  logic [15:0] char_address;
  logic [4:0] row_scan;
  logic [2:0] c_ctl = 3'h6;
  crtsc_raster_t raster;
  int bad_count = 0, checks_done = 0;
  localparam logic [4:0] C_FIRST = 5'h03, C_LAST = 5'h04, C_UL = 5'h05;
  localparam logic [15:0] C_LOC = 16'h1236;

  always #20 clk_sys = ~clk_sys;

  crtsc_top u_dut (
    .clk_sys(clk_sys), .rst(rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .raster(raster), .irq_ack(irq_ack),
    .char_address(char_address), .row_scan(row_scan), .cursor_out(cursor_out),
    .vertical_irq_out_o(vertical_irq_out_o), .vertical_irq_out_oe(vertical_irq_out_oe), .irq(irq)
  );
  crtsc_raster_gen u_far (.clk_sys(clk_sys), .rst(rst), .run(run), .raster(raster));

  task automatic check_bit(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("Counts: %0d checks, %0d mismatches", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic give_up();
    bad_count++;
    $display("Error at %0t: wait ran out", $time);
    end_sim();
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ha, hw, hb;
    int n;
    hb = 1'b0;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!hb) begin
      #1;
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk_sys);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      n++;
      if (n > 50) give_up();
    end
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr;
    int n;
    hr = 1'b0;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!hr) begin
      #1;
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_sys);
      if (ha) s_axi_arvalid <= 1'b0;
      n++;
      if (n > 50) give_up();
    end
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, resp);
    check_word({30'h0, resp}, {30'h0, RESP_OKAY}, "write response");
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    axi_read(a, rd, resp);
    check_word({30'h0, resp}, {30'h0, er}, "read response");
    check_word(rd, e, "read data");
  endtask

  // Cursor output lags the row and address it answers by one clock
  always @(negedge clk_sys) begin
    if (mon_en && exp_ok) check_bit(cursor_out, exp_q, "cursor output");
    exp_ok <= mon_en;
    exp_q <= (c_ctl[CTRL_CURSOR_EN_BIT] && row_scan >= C_FIRST && row_scan <= C_LAST && char_address == C_LOC)
      || (c_ctl[CTRL_UNDERLINE_EN_BIT] && row_scan == 5'(C_UL - 5'h01));
  end

  initial begin
    int n;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    check_bit(vertical_irq_out_oe, 1'b1, "pin released");
    check_bit(irq, 1'b0, "irq after reset");
    rd_chk(ADDR_CONTROL, {29'h0, RST_CONTROL}, RESP_OKAY);
    rd_chk(ADDR_IRQ_MASK, {30'h0, RST_MASK}, RESP_OKAY);
    rd_chk(8'h30, 32'h0000_0000, RESP_SLVERR);
    axi_write(8'h30, 32'h0000_00FF, resp);
    check_word({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped write");
    wr(ADDR_START_LOW, 32'hA5A5_5A34);
    rd_chk(ADDR_START_LOW, 32'h0000_0034, RESP_OKAY);
    // Byte lane 0 switched off: the write is answered but changes nothing
    s_axi_wstrb <= 4'hE;
    wr(ADDR_START_LOW, 32'h0000_00FF);
    s_axi_wstrb <= 4'hF;
    rd_chk(ADDR_START_LOW, 32'h0000_0034, RESP_OKAY);
    wr(ADDR_START_HIGH, 32'h0000_0012);
    wr(ADDR_CURSOR_FIRST, {27'h0, C_FIRST});
    wr(ADDR_CURSOR_LAST, {27'h0, C_LAST});
    wr(ADDR_CURSOR_LOC_HIGH, {24'h0, C_LOC[15:8]});
    wr(ADDR_CURSOR_LOC_LOW, {24'h0, C_LOC[7:0]});
    wr(ADDR_UNDERLINE, {27'h0, C_UL});
    $display("Test registers done");
    for (int i = 0; i < 2; i++) begin
      mon_en = 1'b0;
      c_ctl = (i == 0) ? 3'h2 : 3'h5;
      wr(ADDR_CONTROL, {29'h0, c_ctl});
      wr(ADDR_PRESET_ROW, (i == 0) ? 32'h0000_0003 : 32'h0000_0000);
      wr(ADDR_IRQ_MASK, (i == 0) ? 32'h0000_0001 : 32'h0000_0000);
      mon_en = 1'b1;
      run <= 1'b1;
      n = 0;
      while (raster.vertical_retrace !== 1'b1) begin
        @(negedge clk_sys);
        n++;
        if (n > 200) give_up();
      end
      if (i == 0) check_bit(char_address == 16'h1234, 1'b0, "load before retrace");
      @(negedge clk_sys);
      check_word({11'h0, row_scan, char_address}, {11'h0, (i == 0) ? 5'h03 : 5'h00, 16'h1234}, "retrace load");
      @(posedge clk_sys);
      irq_ack <= 1'b1;
      @(posedge clk_sys);
      irq_ack <= 1'b0;
      #1;
      check_bit(vertical_irq_out_oe, 1'b1, "released after ack");
      check_bit(vertical_irq_out_o, 1'b0, "pin low when inactive");
      n = 0;
      while (vertical_irq_out_oe !== 1'b0) begin
        @(negedge clk_sys);
        n++;
        if (n > 200) give_up();
      end
      check_bit(raster.vertical_display_end, 1'b1, "interrupt at display end");
      check_bit(vertical_irq_out_o, 1'b1, "pin driven high");
      check_bit(irq, (i == 0), "masked irq level");
      @(posedge clk_sys);
      run <= 1'b0;
      #1;
      rd_chk(ADDR_IRQ_STATUS, 32'h0000_0003, RESP_OKAY);
      repeat (4) @(posedge clk_sys);
      #1;
      check_bit(irq, 1'b0, "irq after status read");
      check_bit(vertical_irq_out_oe, 1'b0, "held until ack");
      // Raster is stopped, so the counters stand still while the state word is read
      axi_read(ADDR_STATE, rd, resp);
      check_word(rd, {2'h0, 1'b1, 1'b0, 7'h00, row_scan, char_address}, "state word");
      $display("Test frame %0d done", i);
    end
    end_sim();
  end
endmodule

// ---- hw/crtsc_cursor_cmp.sv ----
// Cursor and underline compare stage with registered output
`timescale 1ns/1ns
module crtsc_cursor_cmp
  import crtsc_pkg::*;
#(
  parameter int ROW_W = 5,
  parameter int ADDR_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ROW_W-1:0] row_scan,
  input wire logic [ADDR_W-1:0] char_address,
  input wire crtsc_cfg_t cfg,
  output logic cursor_out
);
  // Refused at elaboration: the config struct fixes both widths
  if (ROW_W != 5 || ADDR_W != 16) begin : g_width_check
    $error("crtsc_cursor_cmp: widths must match the config struct");
  end
  logic in_height;
  logic at_location;
  logic on_underline;
  logic [ROW_W-1:0] underline_row;
  assign underline_row = cfg.underline_line - 5'h01;
  assign in_height = (row_scan >= cfg.cursor_first_line) && (row_scan <= cfg.cursor_last_line); // see [RULE_05]
  assign at_location = (char_address == cfg.cursor_location); // see [RULE_06]
  assign on_underline = cfg.underline_enable && (row_scan == underline_row); // see [RULE_07]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cursor_out <= 1'b0;
    end else begin
      cursor_out <= (cfg.cursor_enable && at_location && in_height) || on_underline;
    end
  end
  AST_CURSOR_HEIGHT: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE_05]
    (cfg.cursor_enable && at_location && in_height) |=> cursor_out)
    else $error("cursor not shown inside height at location");
  AST_CURSOR_OFF: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE_06]
    (!at_location && !on_underline) |=> !cursor_out)
    else $error("cursor shown away from location");
  AST_UNDERLINE: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE_07]
    (cfg.underline_enable && row_scan == cfg.underline_line - 5'h01) |=> cursor_out)
    else $error("underline missing one line before setting");
endmodule

// ---- hw/crtsc_top.sv ----
// Soft scroll, cursor and vertical interrupt block with AXI4-Lite register slave
`timescale 1ns/1ns
module crtsc_top
  import crtsc_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int ROW_W = 5
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire crtsc_raster_t raster,
  input wire logic irq_ack,
  output logic [ADDR_W-1:0] char_address,
  output logic [ROW_W-1:0] row_scan,
  output logic cursor_out,
  output logic vertical_irq_out_o,
  output logic vertical_irq_out_oe,
  output logic irq
);
  if (ADDR_W != 16 || ROW_W != 5) begin : g_width_check
    $error("crtsc_top: widths must match the config struct");
  end

  logic [7:0] start_address_high;
  logic [7:0] start_address_low;
  logic [4:0] preset_row_scan;
  logic [4:0] cursor_first_line;
  logic [4:0] cursor_last_line;
  logic [7:0] cursor_location_high;
  logic [7:0] cursor_location_low;
  logic [4:0] underline_line;
  logic [2:0] control;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic vint_active;
  logic [ADDR_W-1:0] row_start;
  logic retrace_q;
  logic vend_q;
  crtsc_cfg_t cfg;

  // Write channel: address and data may arrive in either order
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic do_read;
  logic rd_clear_status;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a[1:0] == 2'h0) && (a <= ADDR_STATE);
  endfunction

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= known_addr(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Only byte lane 0 carries data; a write with lane 0 off changes nothing
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      start_address_high <= RST_BYTE;
      start_address_low <= RST_BYTE;
      preset_row_scan <= RST_BYTE[4:0];
      cursor_first_line <= RST_BYTE[4:0];
      cursor_last_line <= RST_BYTE[4:0];
      cursor_location_high <= RST_BYTE;
      cursor_location_low <= RST_BYTE;
      underline_line <= RST_BYTE[4:0];
      control <= RST_CONTROL;
      irq_mask <= RST_MASK;
    end else if (do_write && w_strb[0]) begin
      unique case (aw_addr)
        ADDR_START_HIGH: start_address_high <= w_data[7:0];
        ADDR_START_LOW: start_address_low <= w_data[7:0];
        ADDR_PRESET_ROW: preset_row_scan <= w_data[4:0];
        ADDR_CURSOR_FIRST: cursor_first_line <= w_data[4:0];
        ADDR_CURSOR_LAST: cursor_last_line <= w_data[4:0];
        ADDR_CURSOR_LOC_HIGH: cursor_location_high <= w_data[7:0];
        ADDR_CURSOR_LOC_LOW: cursor_location_low <= w_data[7:0];
        ADDR_UNDERLINE: underline_line <= w_data[4:0];
        ADDR_CONTROL: control <= w_data[2:0];
        ADDR_IRQ_MASK: irq_mask <= w_data[1:0];
        default: begin
        end
      endcase
    end
  end

  // Read channel
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h00000000;
    unique case (s_axi_araddr)
      ADDR_START_HIGH: next_rdata[7:0] = start_address_high;
      ADDR_START_LOW: next_rdata[7:0] = start_address_low;
      ADDR_PRESET_ROW: next_rdata[4:0] = preset_row_scan;
      ADDR_CURSOR_FIRST: next_rdata[4:0] = cursor_first_line;
      ADDR_CURSOR_LAST: next_rdata[4:0] = cursor_last_line;
      ADDR_CURSOR_LOC_HIGH: next_rdata[7:0] = cursor_location_high;
      ADDR_CURSOR_LOC_LOW: next_rdata[7:0] = cursor_location_low;
      ADDR_UNDERLINE: next_rdata[4:0] = underline_line;
      ADDR_CONTROL: next_rdata[2:0] = control;
      ADDR_IRQ_STATUS: next_rdata[1:0] = irq_status;
      ADDR_IRQ_MASK: next_rdata[1:0] = irq_mask;
      ADDR_STATE: next_rdata = {2'h0, vint_active, raster.vertical_retrace, 7'h00, row_scan, char_address};
      default: next_rdata = 32'h00000000;
    endcase
  end
  assign rd_clear_status = do_read && (s_axi_araddr == ADDR_IRQ_STATUS);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= known_addr(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Cursor location and start address are used straight from their registers
  always_comb begin
    cfg.start_address = {start_address_high, start_address_low};
    cfg.preset_row_scan = preset_row_scan;
    cfg.cursor_first_line = cursor_first_line;
    cfg.cursor_last_line = cursor_last_line;
    cfg.cursor_location = {cursor_location_high, cursor_location_low};
    cfg.underline_line = underline_line;
    cfg.graphics_mode = control[CTRL_GRAPHICS_BIT];
    cfg.cursor_enable = control[CTRL_CURSOR_EN_BIT];
    cfg.underline_enable = control[CTRL_UNDERLINE_EN_BIT];
  end

  // Address counter: start address marks the first character in text mode and the first pixel
  // in graphics mode; both simply seed the same counter, so the mode bit does not alter counting.
  // Preset row scan is not forced to zero in graphics; software keeps it zero (see [RULE_04]).
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      char_address <= '0;
      row_start <= '0;
      row_scan <= '0;
    end else if (raster.vertical_retrace) begin
      char_address <= cfg.start_address; // see [RULE_01] see [RULE_03]
      row_start <= cfg.start_address; // see [RULE_01]
      row_scan <= cfg.preset_row_scan; // see [RULE_02]
    end else if (raster.row_end) begin
      row_scan <= row_scan + 5'h01;
      char_address <= row_start;
    end else if (raster.char_tick) begin
      char_address <= char_address + 16'h0001;
    end
  end

  crtsc_cursor_cmp #(
    .ROW_W(ROW_W),
    .ADDR_W(ADDR_W)
  ) u_cursor (
    .clk_sys(clk_sys),
    .rst(rst),
    .row_scan(row_scan),
    .char_address(char_address),
    .cfg(cfg),
    .cursor_out(cursor_out)
  );

  // Vertical interrupt: set on the rising edge of display end, held until acknowledged
  logic vend_rise;
  logic retrace_rise;
  assign vend_rise = raster.vertical_display_end && !vend_q;
  assign retrace_rise = raster.vertical_retrace && !retrace_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      vend_q <= 1'b0;
      retrace_q <= 1'b0;
    end else begin
      vend_q <= raster.vertical_display_end;
      retrace_q <= raster.vertical_retrace;
    end
  end

  // A new display end in the same cycle as the acknowledge keeps the interrupt set
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      vint_active <= 1'b0;
    end else if (vend_rise) begin
      vint_active <= 1'b1; // see [RULE_08]
    end else if (irq_ack) begin
      vint_active <= 1'b0; // see [RULE_10]
    end
  end

  // Pin is driven low-active enable; released (enable high) when idle
  assign vertical_irq_out_o = vint_active;
  assign vertical_irq_out_oe = !vint_active; // see [RULE_09]

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_status <= 2'h0;
    end else begin
      irq_status <= (rd_clear_status ? 2'h0 : irq_status) | {retrace_rise, vend_rise};
    end
  end
  assign irq = |(irq_status & irq_mask);

  AST_SCROLL_LATCH: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE_01]
    raster.vertical_retrace |=> (char_address == $past(cfg.start_address)))
    else $error("start address not latched in retrace");
  AST_ADDR_HOLD: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE_01]
    (!raster.vertical_retrace && !raster.row_end && !raster.char_tick) |=> $stable(char_address))
    else $error("address counter moved outside retrace or tick");
  AST_PRESET_LOAD: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE_02]
    raster.vertical_retrace |=> (row_scan == $past(preset_row_scan)))
    else $error("preset row scan not loaded in retrace");
  AST_ROW_STEP: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE_02]
    (!raster.vertical_retrace && raster.row_end) |=> (row_scan == $past(row_scan) + 5'h01))
    else $error("row scan did not step at line end");
  AST_VINT_SET: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE_08]
    (raster.vertical_display_end && !vend_q) |=> vint_active ##0 !vertical_irq_out_oe)
    else $error("interrupt not raised at display end");
  AST_VINT_QUIET: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE_08]
    (!vint_active && !vend_rise) |=> !vint_active)
    else $error("interrupt raised away from display end");
  AST_STATUS_SET: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE_08]
    vend_rise |=> irq_status[IRQ_VEND_BIT])
    else $error("display end not recorded in status");
  AST_VINT_HOLD: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE_10]
    (vint_active && !irq_ack) |=> vint_active)
    else $error("interrupt dropped without acknowledge");
  AST_VINT_TRISTATE: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE_09]
    (vint_active && irq_ack && !vend_rise) |=> vertical_irq_out_oe)
    else $error("interrupt pin still driven after acknowledge");
  AST_PIN_VALUE: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE_09]
    !vertical_irq_out_oe |-> vertical_irq_out_o)
    else $error("interrupt pin driven without active level");
  // Responses stand until taken, and no new write is accepted meanwhile
  AST_WRITE_REFUSED: assert property (@(posedge clk_sys) disable iff (rst)
    s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
    else $error("write channel open while response pending");
  AST_BRESP_TAKEN: assert property (@(posedge clk_sys) disable iff (rst)
    (s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid)
    else $error("write response not withdrawn after acceptance");
  AST_RRESP_TAKEN: assert property (@(posedge clk_sys) disable iff (rst)
    (s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid)
    else $error("read response not withdrawn after acceptance");
endmodule

// ---- shared/crtsc_pkg.sv ----
// Package for the scroll, cursor and vertical interrupt block: register map, fields, reset values
// How it works
// [RULE_01] Start address is copied into the working address counter only during vertical retrace.
// [RULE_02] Preset row scan loads the row scan counter during that same retrace.
// [RULE_03] Start address names first character (text) or first pixel (graphics).
// [RULE_04] Software should keep preset row scan zero in graphics and scroll by start address.
// [RULE_05] Cursor output is high from cursor first line through cursor last line.
// [RULE_06] Cursor appears where the character address equals the cursor location.
// [RULE_07] Underline shows on cursor output when row scan equals underline line minus one.
// [RULE_08] Vertical interrupt becomes active at the end of the vertical active display.
// [RULE_09] Interrupt pin is driven only while active, otherwise released.
// [RULE_10] Interrupt stays asserted until cleared by an acknowledge.
package crtsc_pkg;
  localparam logic [7:0] ADDR_START_HIGH = 8'h00;
  localparam logic [7:0] ADDR_START_LOW = 8'h04;
  localparam logic [7:0] ADDR_PRESET_ROW = 8'h08;
  localparam logic [7:0] ADDR_CURSOR_FIRST = 8'h0C;
  localparam logic [7:0] ADDR_CURSOR_LAST = 8'h10;
  localparam logic [7:0] ADDR_CURSOR_LOC_HIGH = 8'h14;
  localparam logic [7:0] ADDR_CURSOR_LOC_LOW = 8'h18;
  localparam logic [7:0] ADDR_UNDERLINE = 8'h1C;
  localparam logic [7:0] ADDR_CONTROL = 8'h20;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h24;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
  localparam logic [7:0] ADDR_STATE = 8'h2C;
  localparam int CTRL_GRAPHICS_BIT = 0;
  localparam int CTRL_CURSOR_EN_BIT = 1;
  localparam int CTRL_UNDERLINE_EN_BIT = 2;
  localparam int IRQ_VEND_BIT = 0;
  localparam int IRQ_RETRACE_BIT = 1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_CONTROL = 3'h6;
  localparam logic [1:0] RST_MASK = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic [15:0] start_address;
    logic [4:0] preset_row_scan;
    logic [4:0] cursor_first_line;
    logic [4:0] cursor_last_line;
    logic [15:0] cursor_location;
    logic [4:0] underline_line;
    logic graphics_mode;
    logic cursor_enable;
    logic underline_enable;
  } crtsc_cfg_t;
  typedef struct packed {
    logic vertical_retrace;
    logic vertical_display_end;
    logic row_end;
    logic char_tick;
  } crtsc_raster_t;
endpackage
